// ==== core/usbira_core.sv ====
// USB core end: indirect address/data registers and the internal map.
// Assumes single-cycle strobes from the processor end, USB clock running.
//
// Local design decision: the APB slave port.
`default_nettype none
`include "usbira_map.svh"
module usbira_core #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Processor side
  usbira_if.dev sfr,
  // Clock recovery and status to the user
  output logic cr_enable,
  output logic cr_single_step,
  output logic low_speed_recovery_bit,
  output logic [3:0] endpoint_select_field,
  // Events from the USB engine
  input wire logic [7:0] frame_number_low_in,
  input wire logic [7:0] frame_number_high_in
);
  import usbira_pkg::*;
  localparam int PTR_W = $clog2(FIFO_DEPTH);
  logic busy_reg;
  logic auto_read_flag;
  logic [5:0] internal_register_address;
  usbira_byte_t dat_reg;
  usbira_byte_t xcn_reg;
  logic [1:0] fetch_cnt_reg;
  logic wr_pend_reg;
  usbira_byte_t wr_data_reg;
  usbira_byte_t function_address_reg_reg, power_reg, inen_reg, outen_reg, cmen_reg, clock_recovery_control_reg;
  usbira_byte_t e0cs_reg [4];
  usbira_byte_t incsh_reg [4];
  usbira_byte_t outcsl_reg [4];
  usbira_byte_t outcsh_reg [4];
  usbira_byte_t fifo_mem [4][FIFO_DEPTH];
  logic [$clog2(FIFO_DEPTH)-1:0] fifo_wp [4];
  logic [$clog2(FIFO_DEPTH)-1:0] fifo_rp [4];
  logic [7:0] e0_count_reg;
  logic [1:0] ep;
  logic adr_wr, dat_wr, dat_rd, int_rd_done;

  assign ep = endpoint_select_field[1:0];
  assign adr_wr = sfr.sfr_wr && sfr.sfr_addr == `USBIRA_ADR_OFS;
  assign dat_wr = sfr.sfr_wr && sfr.sfr_addr == `USBIRA_DAT_OFS;
  assign dat_rd = sfr.sfr_rd && sfr.sfr_addr == `USBIRA_DAT_OFS;
  assign int_rd_done = busy_reg && !wr_pend_reg && fetch_cnt_reg == 2'h0;

  function automatic usbira_byte_t rd_map(input logic [5:0] a);
    usbira_byte_t v;
    v = 8'h00;
    unique case (a)
      `USBIRA_A_FUNCTION_ADDRESS_REG: v = function_address_reg_reg;
      `USBIRA_A_POWER: v = power_reg;
      `USBIRA_A_INEN: v = inen_reg;
      `USBIRA_A_OUTEN: v = outen_reg;
      `USBIRA_A_CMEN: v = cmen_reg;
      `USBIRA_A_INFLG, `USBIRA_A_OUTFLG, `USBIRA_A_CMFLG: v = 8'h00;
      `USBIRA_A_FRML: v = frame_number_low_in;
      `USBIRA_A_FRMH: v = frame_number_high_in;
      `USBIRA_A_INDEX: v = {4'h0, endpoint_select_field};
      `USBIRA_A_CLOCK_RECOVERY_CONTROL: v = clock_recovery_control_reg;
      `USBIRA_A_E0CS: v = e0cs_reg[ep];
      `USBIRA_A_INCSH: v = incsh_reg[ep];
      `USBIRA_A_OUTCSL: v = outcsl_reg[ep];
      `USBIRA_A_OUTCSH: v = outcsh_reg[ep];
      `USBIRA_A_EP0_RECEIVED_COUNT: v = e0_count_reg;
      default: begin
        if (a >= `USBIRA_A_FIFO0 && a <= `USBIRA_A_FIFO3) begin
          v = fifo_mem[a[1:0]][fifo_rp[a[1:0]]];
        end
      end
    endcase
    return v;
  endfunction

  // Indirect address register, busy and auto-read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      auto_read_flag <= 1'b0;
      internal_register_address <= 6'h00;
      fetch_cnt_reg <= 2'h0;
    end else begin
      if (adr_wr) begin
        auto_read_flag <= sfr.sfr_wdata[`USBIRA_AUTO_BIT];
        internal_register_address <= sfr.sfr_wdata[5:0];
      end
      if ((adr_wr && sfr.sfr_wdata[`USBIRA_BUSY_BIT]) || (dat_rd && auto_read_flag)) begin
        busy_reg <= 1'b1;
        fetch_cnt_reg <= `USBIRA_FETCH_CYC;
      end else if (dat_wr) begin
        busy_reg <= 1'b1;
        fetch_cnt_reg <= `USBIRA_FETCH_CYC;
      end else if (busy_reg && fetch_cnt_reg != 2'h0) begin
        fetch_cnt_reg <= fetch_cnt_reg - 2'h1;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Data register captures fetched data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_reg <= 8'h00;
    end else if (dat_wr) begin
      dat_reg <= sfr.sfr_wdata;
    end else if (int_rd_done) begin
      dat_reg <= rd_map(internal_register_address);
    end
  end

  // Pending internal write, performed while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_pend_reg <= 1'b0;
      wr_data_reg <= 8'h00;
    end else if (dat_wr) begin
      wr_pend_reg <= 1'b1;
      wr_data_reg <= sfr.sfr_wdata;
    end else if (busy_reg && fetch_cnt_reg == 2'h0) begin
      wr_pend_reg <= 1'b0;
    end
  end

  logic do_wr;
  assign do_wr = wr_pend_reg && busy_reg && fetch_cnt_reg == 2'h0;

  // Internal common registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_address_reg_reg <= 8'h00;
      power_reg <= 8'h00;
      inen_reg <= 8'h00;
      outen_reg <= 8'h00;
      cmen_reg <= 8'h00;
      clock_recovery_control_reg <= `USBIRA_CLOCK_RECOVERY_CONTROL_RST;
      endpoint_select_field <= 4'h0;
    end else if (do_wr) begin
      unique case (internal_register_address)
        `USBIRA_A_FUNCTION_ADDRESS_REG: function_address_reg_reg <= wr_data_reg;
        `USBIRA_A_POWER: power_reg <= wr_data_reg;
        `USBIRA_A_INEN: inen_reg <= wr_data_reg;
        `USBIRA_A_OUTEN: outen_reg <= wr_data_reg;
        `USBIRA_A_CMEN: cmen_reg <= wr_data_reg;
        `USBIRA_A_INDEX: endpoint_select_field <= wr_data_reg[3:0];
        `USBIRA_A_CLOCK_RECOVERY_CONTROL: clock_recovery_control_reg <= wr_data_reg;
        default: begin
        end
      endcase
    end
  end

  // Indexed registers; writes under reserved endpoint selects are ignored, reads use the low two select bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        e0cs_reg[i] <= 8'h00;
        incsh_reg[i] <= 8'h00;
        outcsl_reg[i] <= 8'h00;
        outcsh_reg[i] <= 8'h00;
      end
    end else if (do_wr && endpoint_select_field[3:2] == 2'h0) begin
      unique case (internal_register_address)
        `USBIRA_A_E0CS: e0cs_reg[ep] <= wr_data_reg;
        `USBIRA_A_INCSH: incsh_reg[ep] <= wr_data_reg;
        `USBIRA_A_OUTCSL: outcsl_reg[ep] <= wr_data_reg;
        `USBIRA_A_OUTCSH: outcsh_reg[ep] <= wr_data_reg;
        default: begin
        end
      endcase
    end
  end

  // Endpoint FIFO byte ports
  logic fifo_hit;
  assign fifo_hit = internal_register_address >= `USBIRA_A_FIFO0 &&
                    internal_register_address <= `USBIRA_A_FIFO3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        fifo_wp[i] <= '0;
        fifo_rp[i] <= '0;
      end
      e0_count_reg <= 8'h00;
    end else begin
      if (do_wr && fifo_hit) begin
        fifo_mem[internal_register_address[1:0]][fifo_wp[internal_register_address[1:0]]]
          <= wr_data_reg;
        fifo_wp[internal_register_address[1:0]] <=
          fifo_wp[internal_register_address[1:0]] + PTR_W'(1);
        if (internal_register_address[1:0] == 2'h0) begin
          e0_count_reg <= e0_count_reg + 8'h01;
        end
      end else if (int_rd_done && fifo_hit) begin
        fifo_rp[internal_register_address[1:0]] <=
          fifo_rp[internal_register_address[1:0]] + PTR_W'(1);
        if (internal_register_address[1:0] == 2'h0 && e0_count_reg != 8'h00) begin
          e0_count_reg <= e0_count_reg - 8'h01;
        end
      end
    end
  end

  // Transceiver control with speed select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xcn_reg <= 8'h00;
    end else if (sfr.sfr_wr && sfr.sfr_addr == `USBIRA_XCN_OFS) begin
      xcn_reg <= sfr.sfr_wdata;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sfr.sfr_rdata <= 8'h00;
      sfr.speed_full <= 1'b0;
      cr_enable <= 1'b0;
      cr_single_step <= 1'b0;
      low_speed_recovery_bit <= 1'b0;
    end else begin
      sfr.speed_full <= xcn_reg[`USBIRA_SPEED_BIT];
      cr_enable <= clock_recovery_control_reg[`USBIRA_CR_EN_BIT];
      cr_single_step <= clock_recovery_control_reg[`USBIRA_CR_SS_BIT];
      low_speed_recovery_bit <= clock_recovery_control_reg[`USBIRA_CR_LOW_BIT];
      unique case (sfr.sfr_addr)
        `USBIRA_ADR_OFS: sfr.sfr_rdata <= {busy_reg, auto_read_flag, internal_register_address};
        `USBIRA_DAT_OFS: sfr.sfr_rdata <= dat_reg;
        `USBIRA_XCN_OFS: sfr.sfr_rdata <= xcn_reg;
        default: sfr.sfr_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== core/usbira_map.svh ====
// Constants of the indirect register access path to the USB core.
// Assumes inclusion by the package and both ends; definitions only.
`ifndef USBIRA_MAP_SVH
`define USBIRA_MAP_SVH
`define USBIRA_ADR_OFS 8'h96
`define USBIRA_DAT_OFS 8'h97
`define USBIRA_XCN_OFS 8'hd7
`define USBIRA_CMD_OFS 12'h000
`define USBIRA_STS_OFS 12'h004
`define USBIRA_RDATA_OFS 12'h008
`define USBIRA_BUSY_BIT 7
`define USBIRA_AUTO_BIT 6
`define USBIRA_SPEED_BIT 5
`define USBIRA_CR_EN_BIT 7
`define USBIRA_CR_SS_BIT 6
`define USBIRA_CR_LOW_BIT 5
`define USBIRA_A_FUNCTION_ADDRESS_REG 6'h00
`define USBIRA_A_POWER 6'h01
`define USBIRA_A_INFLG 6'h02
`define USBIRA_A_OUTFLG 6'h04
`define USBIRA_A_CMFLG 6'h06
`define USBIRA_A_INEN 6'h07
`define USBIRA_A_OUTEN 6'h09
`define USBIRA_A_CMEN 6'h0b
`define USBIRA_A_FRML 6'h0c
`define USBIRA_A_FRMH 6'h0d
`define USBIRA_A_INDEX 6'h0e
`define USBIRA_A_CLOCK_RECOVERY_CONTROL 6'h0f
`define USBIRA_A_E0CS 6'h11
`define USBIRA_A_INCSH 6'h12
`define USBIRA_A_OUTCSL 6'h14
`define USBIRA_A_OUTCSH 6'h15
`define USBIRA_A_EP0_RECEIVED_COUNT 6'h16
`define USBIRA_A_OUTCNTH 6'h17
`define USBIRA_A_FIFO0 6'h20
`define USBIRA_A_FIFO3 6'h23
`define USBIRA_CLOCK_RECOVERY_CONTROL_RST 8'h09
`define USBIRA_FETCH_CYC 2'h2
`define USBIRA_NUM_EP 3'h4
`endif

// ==== core/usbira_pkg.sv ====
// Types shared by both ends of the indirect register path.
// Assumes the constants header is on the include path.
`default_nettype none
`include "usbira_map.svh"
package usbira_pkg;
  typedef logic [7:0] usbira_byte_t;
  typedef enum logic [1:0] {USBIRA_SFR_NONE, USBIRA_SFR_RD, USBIRA_SFR_WR} usbira_op_t;
endpackage
`default_nettype wire

// ==== core/usbira_if.sv ====
// Special function register bus between processor end and USB core end.
// Assumes one clock shared by both parties.
`default_nettype none
interface usbira_if (
  input wire logic pclk
);
  import usbira_pkg::*;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_addr;
  usbira_byte_t sfr_wdata;
  usbira_byte_t sfr_rdata;
  logic speed_full;
  modport host (output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, input sfr_rdata, speed_full);
  modport dev (input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, output sfr_rdata, speed_full);
endinterface
`default_nettype wire

// ==== core/usbira_host.sv ====
// Processor end: APB slave with command registers, drives the SFR bus.
// Assumes the core end answers reads one cycle after the strobe.
`default_nettype none
`include "usbira_map.svh"
module usbira_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // SFR bus
  usbira_if.host sfr
);
  import usbira_pkg::*;
  typedef enum logic [1:0] {USBIRA_IDLE, USBIRA_WAIT, USBIRA_CAPT} usbira_st_t;
  usbira_st_t st_reg;
  logic [31:0] rdata_reg;
  logic done_reg;
  logic acc, hit;
  assign acc = psel && penable && !pready;
  assign hit = paddr == `USBIRA_CMD_OFS || paddr == `USBIRA_STS_OFS ||
               paddr == `USBIRA_RDATA_OFS;

  // Command register: bit 8 write, bits 7-0 address, bits 23-16 data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sfr.sfr_wr <= 1'b0;
      sfr.sfr_rd <= 1'b0;
      sfr.sfr_addr <= 8'h00;
      sfr.sfr_wdata <= 8'h00;
      st_reg <= USBIRA_IDLE;
      rdata_reg <= 32'h0;
      done_reg <= 1'b0;
    end else begin
      sfr.sfr_wr <= 1'b0;
      sfr.sfr_rd <= 1'b0;
      unique case (st_reg)
        USBIRA_IDLE: begin
          if (acc && pwrite && paddr == `USBIRA_CMD_OFS) begin
            sfr.sfr_addr <= pwdata[7:0];
            sfr.sfr_wdata <= pwdata[23:16];
            sfr.sfr_wr <= pwdata[8];
            sfr.sfr_rd <= !pwdata[8];
            done_reg <= 1'b0;
            st_reg <= pwdata[8] ? USBIRA_IDLE : USBIRA_WAIT;
            done_reg <= pwdata[8];
          end
        end
        USBIRA_WAIT: st_reg <= USBIRA_CAPT;
        USBIRA_CAPT: begin
          rdata_reg <= {24'h0, sfr.sfr_rdata};
          done_reg <= 1'b1;
          st_reg <= USBIRA_IDLE;
        end
        default: st_reg <= USBIRA_IDLE;
      endcase
    end
  end

  // APB answer one cycle into access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc;
      pslverr <= acc && !hit;
      if (acc && !pwrite) begin
        unique case (paddr)
          `USBIRA_STS_OFS: prdata <= {29'h0, sfr.speed_full, st_reg == USBIRA_IDLE, done_reg};
          `USBIRA_RDATA_OFS: prdata <= rdata_reg;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/usbira_properties.sv ====
// Checker of the SFR bus between the processor end and the USB core end.
// Assumes one clock, active-low reset, instanced beside the interface.
`default_nettype none
module usbira_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // SFR bus
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire usbira_pkg::usbira_byte_t sfr_wdata,
  input wire usbira_pkg::usbira_byte_t sfr_rdata,
  input wire logic speed_full
);
  import usbira_pkg::*;
  logic [5:0] ia_reg;
  logic ok_reg;
  logic auto_reg;
  logic [3:0] age_reg;
  logic aw;
  logic dw;
  logic launch;
  logic settled;
  logic xw;
  assign xw = sfr_wr && sfr_addr == 8'hd7;
  assign aw = sfr_wr && sfr_addr == 8'h96;
  assign dw = sfr_wr && sfr_addr == 8'h97;
  assign launch = (aw && sfr_wdata[7]) || dw || (sfr_rd && sfr_addr == 8'h97 && auto_reg);
  assign settled = sfr_rd && sfr_addr == 8'h97 && ok_reg && age_reg > 4'h8;
  // Last indirect address and whether the data register holds a fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ia_reg <= 6'h00;
      auto_reg <= 1'b0;
      ok_reg <= 1'b0;
    end else if (aw) begin
      ia_reg <= sfr_wdata[5:0];
      auto_reg <= sfr_wdata[6];
      ok_reg <= sfr_wdata[7];
    end else if (dw) begin
      ok_reg <= 1'b0;
    end
  end
  // Cycles since the last access was launched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_reg <= 4'hf;
    end else if (launch) begin
      age_reg <= 4'h0;
    end else if (age_reg != 4'hf) begin
      age_reg <= age_reg + 4'h1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_wr_pulse;
    sfr_wr |=> !sfr_wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_rd_pulse;
    sfr_rd |=> !sfr_rd;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  property p_one_op;
    !(sfr_wr && sfr_rd);
  endproperty
  a_one_op: assert property (p_one_op) else $error("read and write together");
  property p_addr_holds;
    $changed(sfr_addr) |-> sfr_wr || sfr_rd;
  endproperty
  a_addr_holds: assert property (p_addr_holds) else $error("address moved idle");
  property p_busy_clears;
    sfr_rd && sfr_addr == 8'h96 && age_reg > 4'h8 |=> !sfr_rdata[7];
  endproperty
  a_busy_clears: assert property (p_busy_clears) else $error("busy stuck");
  property p_speed_sel;
    xw |-> ##2 speed_full == $past(sfr_wdata[5], 2);
  endproperty
  a_speed_sel: assert property (p_speed_sel) else $error("speed not taken");
  property p_speed_holds;
    $changed(speed_full) |-> $past(xw, 2);
  endproperty
  a_speed_holds: assert property (p_speed_holds) else $error("speed moved");
  property p_index_upper;
    settled && ia_reg == 6'h0e |=> sfr_rdata[7:4] == 4'h0;
  endproperty
  a_index_upper: assert property (p_index_upper) else $error("index upper set");
  property p_flags_zero;
    settled && (ia_reg == 6'h02 || ia_reg == 6'h04 || ia_reg == 6'h06) |=> sfr_rdata == 8'h00;
  endproperty
  a_flags_zero: assert property (p_flags_zero) else $error("flags not zero");
endmodule
`default_nettype wire

// ==== sim/usb_indirect_register_access_tb_top.sv ====
// Bench of the indirect register path: both ends joined, driven over APB.
// Assumes the design files and the checker are compiled before it.
`default_nettype none
module usb_indirect_register_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import usbira_pkg::*;
  typedef struct packed {logic w; logic [5:0] a; logic [7:0] d; logic [7:0] m; logic [7:0] e;}
    usbira_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cr_en, cr_ss, cr_low, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] ep_sel;
  logic [7:0] q;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  usbira_row_t rows [15] = '{{1'b1, 6'h07, 8'ha5, 8'hff, 8'ha5}, {1'b1, 6'h09, 8'h3c, 8'hff, 8'h3c},
    {1'b1, 6'h0b, 8'h5a, 8'hff, 8'h5a}, {1'b0, 6'h02, 8'h00, 8'hff, 8'h00},
    {1'b0, 6'h04, 8'h00, 8'hff, 8'h00}, {1'b0, 6'h06, 8'h00, 8'hff, 8'h00},
    {1'b0, 6'h0c, 8'h00, 8'hff, 8'h3c}, {1'b0, 6'h0d, 8'h00, 8'hff, 8'h07},
    {1'b1, 6'h0f, 8'he9, 8'he0, 8'he0}, {1'b1, 6'h0e, 8'hf2, 8'hff, 8'h02},
    {1'b1, 6'h00, 8'h35, 8'hff, 8'h35}, {1'b1, 6'h01, 8'h0a, 8'hff, 8'h0a},
    {1'b1, 6'h11, 8'h81, 8'hff, 8'h81}, {1'b1, 6'h14, 8'h42, 8'hff, 8'h42},
    {1'b1, 6'h15, 8'h18, 8'hff, 8'h18}};
  usbira_if usbira_if_inst (.pclk(pclk));
  usbira_host usbira_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sfr(usbira_if_inst.host));
  usbira_core usbira_core_inst (.pclk(pclk), .presetn(presetn), .sfr(usbira_if_inst.dev),
    .cr_enable(cr_en), .cr_single_step(cr_ss), .low_speed_recovery_bit(cr_low),
    .endpoint_select_field(ep_sel), .frame_number_low_in(8'h3c), .frame_number_high_in(8'h07));
  usbira_properties usbira_properties_inst (.pclk(pclk), .presetn(presetn),
    .sfr_wr(usbira_if_inst.sfr_wr), .sfr_rd(usbira_if_inst.sfr_rd),
    .sfr_addr(usbira_if_inst.sfr_addr), .sfr_wdata(usbira_if_inst.sfr_wdata),
    .sfr_rdata(usbira_if_inst.sfr_rdata), .speed_full(usbira_if_inst.speed_full));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rst();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // One SFR command, then wait for idle and fetch the last read byte
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, 12'h000, {8'h00, d, 7'h00, w, a});
    r = 0;
    while (r[1] !== 1'b1) apb(1'b0, 12'h004, 0);
    apb(1'b0, 12'h008, 0);
    q = r[7:0];
  endtask
  task automatic wait_free();
    q = 8'h80;
    while (q[7] !== 1'b0) sfr(1'b0, 8'h96, 8'h00);
  endtask
  task automatic uwr(input logic [5:0] a, input logic [7:0] d);
    wait_free();
    sfr(1'b1, 8'h96, {2'b00, a});
    sfr(1'b1, 8'h97, d);
  endtask
  task automatic urd(input logic [5:0] a);
    wait_free();
    sfr(1'b1, 8'h96, {2'b10, a});
    wait_free();
    sfr(1'b0, 8'h97, 8'h00);
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rst();
    foreach (rows[i]) begin
      if (rows[i].w) uwr(rows[i].a, rows[i].d);
      urd(rows[i].a);
      chk(q & rows[i].m, rows[i].e);
    end
    chk({cr_en, cr_ss, cr_low, ep_sel}, 7'h72);
    for (int ep = 1; ep < 4; ep++) begin
      uwr(6'h0e, 8'(ep));
      uwr(6'h12, 8'(ep << 5));
    end
    uwr(6'h0e, 8'h05);
    uwr(6'h12, 8'hff);
    for (int ep = 1; ep < 4; ep++) begin
      uwr(6'h0e, (ep == 1) ? 8'h05 : 8'(ep));
      urd(6'h12);
      chk(q, 8'(ep << 5));
    end
    uwr(6'h21, 8'h77);
    uwr(6'h20, 8'h10);
    for (int i = 1; i < 4; i++) begin
      wait_free();
      sfr(1'b1, 8'h97, 8'(8'h10 + i));
    end
    uwr(6'h0e, 8'h00);
    urd(6'h16);
    chk(q, 8'h04);
    wait_free();
    sfr(1'b1, 8'h96, 8'he0);
    for (int i = 0; i < 3; i++) begin
      wait_free();
      sfr(1'b0, 8'h97, 8'h00);
      chk(q, 8'(8'h10 + i));
    end
    urd(6'h16);
    chk(q, 8'h00);
    urd(6'h21);
    sfr(1'b0, 8'h97, 8'h00);
    chk(q, 8'h77);
    for (int s = 0; s < 2; s++) begin
      sfr(1'b1, 8'hd7, (s == 0) ? 8'h20 : 8'h00);
      apb(1'b0, 12'h004, 0);
      chk(r[2], s == 0);
    end
    apb(1'b0, 12'h00c, 0);
    chk(e, 1'b1);
    sfr(1'b1, 8'h96, 8'h0e);
    sfr(1'b0, 8'h96, 8'h00);
    chk(q, 8'h0e);
    rst();
    chk({cr_en, cr_ss, cr_low, ep_sel}, 7'h00);
    sfr(1'b0, 8'h96, 8'h00);
    chk(q, 8'h00);
    urd(6'h0f);
    chk(q, 8'h09);
    urd(6'h0e);
    chk(q, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
